// [tpic_regs.svh]
`ifndef TPIC_REGS_SVH
`define TPIC_REGS_SVH

// register indices on the plain register port
`define TPIC_ADDR_IE      3'h0
`define TPIC_ADDR_PRESC   3'h1
`define TPIC_ADDR_T2CFG   3'h2
`define TPIC_ADDR_STATUS  3'h3
`define TPIC_ADDR_MASK    3'h4
`define TPIC_ADDR_WDOG    3'h5

// reset and power-down values
`define TPIC_IE_RST       4'h0
`define TPIC_PRESC_RST    4'h0
`define TPIC_T2CFG_RST    4'h8
`define TPIC_PD_IE        4'h0
`define TPIC_PD_PRESC     4'h0

// field positions
`define TPIC_T2CFG_T1RUN  0
`define TPIC_IE_SPARE     1

// timer 1 source codes
`define TPIC_T1SRC_PRESC  2'h0
`define TPIC_T1SRC_CARR   2'h1
`define TPIC_T1SRC_CARR2  2'h2

// prescaler terminal counts (divide minus one)
`define TPIC_PRESC_DIV4   3'h3
`define TPIC_PRESC_DIV8   3'h7

// timer 2 reload values (period minus one)
`define TPIC_T2_LEN14     14'h3FFF
`define TPIC_T2_LEN13     14'h1FFF

`endif

// [tpic_pkg.sv]
package tpic_pkg;

    // interrupt enable register layout
    typedef struct packed {
        logic t2_ie;
        logic t1_ie;
        logic spare;
        logic ext_ie;
    } tpic_ie_t;

    // prescaler and timer 1 source register layout
    typedef struct packed {
        logic       presc_run;
        logic       presc_div8;
        logic [1:0] t1_src;
    } tpic_presc_t;

    // timer 2 configuration and timer 1 run register layout
    typedef struct packed {
        logic       t2_src_presc;
        logic [1:0] t2_len;
        logic       t1_run;
    } tpic_t2cfg_t;

    // one bit per interrupt source, also the status and mask layout
    typedef struct packed {
        logic wdog;
        logic t2;
        logic t1;
        logic ext;
    } tpic_evt_t;

endpackage : tpic_pkg

// [tpic_ctrl.sv]
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tpic_regs.svh"

module tpic_ctrl (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // register port
    input  wire logic [2:0]           reg_addr,
    input  wire logic [3:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [3:0]           reg_rdata,
    // instruction strobes from the core
    input  wire logic                 timer1_poll_skip,
    input  wire logic                 timer2_poll_skip,
    input  wire logic                 ext_irq_poll_skip,
    input  wire logic                 watchdog_kick,
    input  wire logic                 power_down_enter,
    input  wire logic                 table_lookup_instr,
    input  wire logic                 return_instr,
    input  wire tpic_pkg::tpic_evt_t  irq_ack,
    // event sources
    input  wire logic                 external_irq_event,
    input  wire logic                 timer1_underflow,
    input  wire logic                 carrier_out,
    input  wire logic                 sub_osc_clock,
    // results to the core and timers
    output logic                      skip_nullify,
    output logic                      skip_short,
    output tpic_pkg::tpic_evt_t       irq_request,
    output logic                      prescaler_output,
    output logic                      timer1_count_en,
    output logic                      timer2_underflow,
    output logic      [13:0]          timer2_count,
    output logic                      watchdog_reset,
    output logic                      irq
);

    tpic_pkg::tpic_ie_t    ie;
    tpic_pkg::tpic_presc_t presc_cfg;
    tpic_pkg::tpic_t2cfg_t t2cfg;
    tpic_pkg::tpic_evt_t   status;
    tpic_pkg::tpic_evt_t   mask;
    tpic_pkg::tpic_evt_t   flag;
    logic                  watchdog_flag;
    logic                  watchdog_enable_flag;
    logic [2:0]            presc_cnt;
    logic [2:0]            presc_last;
    logic                  presc_tick;
    logic                  carr_d;
    logic                  carr_rise;
    logic                  carr_half;
    logic                  carr_half_rise;
    logic                  t1_src_tick;
    logic                  sub_s1;
    logic                  sub_s2;
    logic                  sub_s3;
    logic                  sub_lev;
    logic                  sub_lev_d;
    logic                  t2_tick;
    logic [13:0]           t2_reload;
    logic                  t2_uf;
    logic                  wd_trip;
    logic                  skip_hit;
    tpic_pkg::tpic_evt_t   ev_set;
    tpic_pkg::tpic_evt_t   flag_clr;
    logic                  status_rd;

    function automatic logic wr_hit(input logic [2:0] a);
        wr_hit = reg_wr && (reg_addr == a);
    endfunction : wr_hit

    // control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ie <= `TPIC_IE_RST;
        end else if (power_down_enter) begin
            ie <= `TPIC_PD_IE;
        end else if (wr_hit(`TPIC_ADDR_IE)) begin
            ie <= reg_wdata; // spare bit is stored as written
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            presc_cfg <= `TPIC_PRESC_RST;
        end else if (power_down_enter) begin
            presc_cfg <= `TPIC_PD_PRESC;
        end else if (wr_hit(`TPIC_ADDR_PRESC)) begin
            presc_cfg <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t2cfg <= `TPIC_T2CFG_RST;
        end else if (power_down_enter) begin
            t2cfg.t1_run <= 1'b0; // upper bits kept
        end else if (wr_hit(`TPIC_ADDR_T2CFG)) begin
            t2cfg <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask <= 4'h0;
        end else if (wr_hit(`TPIC_ADDR_MASK)) begin
            mask <= reg_wdata;
        end
    end

    // prescaler
    assign presc_last = presc_cfg.presc_div8 ? `TPIC_PRESC_DIV8 : `TPIC_PRESC_DIV4;
    assign presc_tick = presc_cfg.presc_run && (presc_cnt == presc_last);

    always_ff @(posedge clk) begin
        if (rst || !presc_cfg.presc_run) begin
            presc_cnt <= 3'h0; // stopped and initialised
        end else if (presc_cnt >= presc_last) begin
            presc_cnt <= 3'h0;
        end else begin
            presc_cnt <= presc_cnt + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prescaler_output <= 1'b0;
        end else begin
            prescaler_output <= presc_tick;
        end
    end

    // carrier edges and carrier halved
    assign carr_rise      = carrier_out && !carr_d;
    assign carr_half_rise = carr_rise && carr_half;

    always_ff @(posedge clk) begin
        if (rst) begin
            carr_d    <= 1'b0;
            carr_half <= 1'b0;
        end else begin
            carr_d <= carrier_out;
            if (carr_rise) begin
                carr_half <= !carr_half;
            end
        end
    end

    // timer 1 count enable
    always_comb begin
        unique case (presc_cfg.t1_src)
            `TPIC_T1SRC_PRESC: t1_src_tick = presc_tick;
            `TPIC_T1SRC_CARR:  t1_src_tick = carr_rise;
            `TPIC_T1SRC_CARR2: t1_src_tick = carr_half_rise;
            default:           t1_src_tick = 1'b0;           // no source
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timer1_count_en <= 1'b0;
        end else begin
            timer1_count_en <= t2cfg.t1_run && t1_src_tick; // forced low while stopped
        end
    end

    // sub oscillator clock sampled as a pin
    always_ff @(posedge clk) begin
        if (rst) begin
            sub_s1    <= 1'b0;
            sub_s2    <= 1'b0;
            sub_s3    <= 1'b0;
            sub_lev   <= 1'b0;
            sub_lev_d <= 1'b0;
        end else begin
            sub_s1    <= sub_osc_clock;
            sub_s2    <= sub_s1;
            sub_s3    <= sub_s2;
            sub_lev_d <= sub_lev;
            if (sub_s2 == sub_s3) begin
                sub_lev <= sub_s3;
            end
        end
    end

    // timer 2 counter
    assign t2_tick   = t2cfg.t2_src_presc ? presc_tick : (sub_lev && !sub_lev_d);
    // unavailable length codes fall back to the full length
    assign t2_reload = (t2cfg.t2_len == 2'h1) ? `TPIC_T2_LEN13 : `TPIC_T2_LEN14;
    assign t2_uf     = t2_tick && (timer2_count == 14'h0000);

    always_ff @(posedge clk) begin
        if (rst) begin
            timer2_count <= `TPIC_T2_LEN14;
        end else if (t2_uf) begin
            timer2_count <= t2_reload;
        end else if (t2_tick) begin
            timer2_count <= timer2_count - 14'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timer2_underflow <= 1'b0;
        end else begin
            timer2_underflow <= t2_uf;
        end
    end

    // watchdog: second underflow without a kick trips the reset
    assign wd_trip = t2_uf && watchdog_enable_flag && watchdog_flag;

    always_ff @(posedge clk) begin
        if (rst) begin
            watchdog_flag <= 1'b0;
        end else if (t2_uf && watchdog_enable_flag) begin
            watchdog_flag <= 1'b1;
        end else if (watchdog_kick) begin
            watchdog_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            watchdog_enable_flag <= 1'b0;
        end else if (watchdog_kick) begin
            watchdog_enable_flag <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            watchdog_reset <= 1'b0;
        end else begin
            watchdog_reset <= wd_trip;
        end
    end

    // request flags, cleared by a poll skip only while the interrupt is off
    assign ev_set = '{wdog: wd_trip, t2: t2_uf, t1: timer1_underflow, ext: external_irq_event};

    always_comb begin
        flag_clr      = irq_ack;
        flag_clr.wdog = 1'b0;
        flag_clr.t2   = (timer2_poll_skip && !ie.t2_ie) || (irq_ack.t2 && ie.t2_ie);
        flag_clr.t1   = (timer1_poll_skip && !ie.t1_ie) || (irq_ack.t1 && ie.t1_ie);
        flag_clr.ext  = (ext_irq_poll_skip && !ie.ext_ie) || (irq_ack.ext && ie.ext_ie);
    end

    // a new event beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 4'h0;
        end else begin
            flag <= ev_set | (flag & ~flag_clr);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_request <= 4'h0;
        end else begin
            irq_request.wdog <= 1'b0;
            irq_request.t2   <= flag.t2 && ie.t2_ie && !flag_clr.t2;
            irq_request.t1   <= flag.t1 && ie.t1_ie && !flag_clr.t1;
            irq_request.ext  <= flag.ext && ie.ext_ie && !flag_clr.ext;
        end
    end

    // skip result: nullify only, the program counter is the core's business
    assign skip_hit = (timer2_poll_skip && !ie.t2_ie && flag.t2)
                    || (timer1_poll_skip && !ie.t1_ie && flag.t1)
                    || (ext_irq_poll_skip && !ie.ext_ie && flag.ext);

    always_ff @(posedge clk) begin
        if (rst) begin
            skip_nullify <= 1'b0;
            skip_short   <= 1'b0;
        end else begin
            skip_nullify <= skip_hit;
            skip_short   <= skip_hit && (table_lookup_instr || return_instr);
        end
    end

    // software status, cleared by reading it
    assign status_rd = reg_rd && (reg_addr == `TPIC_ADDR_STATUS);

    always_ff @(posedge clk) begin
        if (rst) begin
            status <= 4'h0;
        end else begin
            status <= ev_set | (status & {4{!status_rd}});
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((ev_set | (status & {4{!status_rd}})) & mask);
        end
    end

    // read data for one cycle only
    always_ff @(posedge clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 4'h0;
        end else begin
            unique case (reg_addr)
                `TPIC_ADDR_IE:     reg_rdata <= ie;
                `TPIC_ADDR_PRESC:  reg_rdata <= presc_cfg;
                `TPIC_ADDR_T2CFG:  reg_rdata <= t2cfg;
                `TPIC_ADDR_STATUS: reg_rdata <= status;
                `TPIC_ADDR_MASK:   reg_rdata <= mask;
                `TPIC_ADDR_WDOG:   reg_rdata <= {2'h0, watchdog_enable_flag, watchdog_flag};
                default:           reg_rdata <= 4'h0;
            endcase
        end
    end

endmodule : tpic_ctrl
`default_nettype wire

// [tpic_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tpic_core_model (
    // command from the bench
    input  wire logic       go,
    input  wire logic [1:0] op,
    // instruction strobes
    output logic            t1_skip,
    output logic            t2_skip,
    output logic            ext_skip,
    output logic            kick
);
    // one strobe per executed instruction, never two at once
    assign t1_skip  = go && op == 2'h0;
    assign t2_skip  = go && op == 2'h1;
    assign ext_skip = go && op == 2'h2;
    assign kick     = go && op == 2'h3;
endmodule : tpic_core_model
`default_nettype wire

// [tpic_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module tpic_ctrl_chk (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // watched ports
    input  wire logic                reg_rd,
    input  wire logic [3:0]          reg_rdata,
    input  wire logic                timer1_poll_skip,
    input  wire logic                timer2_poll_skip,
    input  wire logic                ext_irq_poll_skip,
    input  wire logic                table_lookup_instr,
    input  wire logic                return_instr,
    input  wire logic                power_down_enter,
    input  wire logic                skip_nullify,
    input  wire logic                skip_short,
    input  wire tpic_pkg::tpic_evt_t irq_request,
    input  wire logic                prescaler_output,
    input  wire logic [13:0]         timer2_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 4'h0)
        else $error("read data outside read slot");
    chk_skip_cause: assert property (skip_nullify |->
        $past(timer1_poll_skip || timer2_poll_skip || ext_irq_poll_skip))
        else $error("nullify without a poll skip");
    chk_skip_short: assert property (skip_nullify |->
        skip_short == $past(table_lookup_instr || return_instr))
        else $error("short skip mismatch");
    chk_presc_gap: assert property (prescaler_output |=> !prescaler_output [*3])
        else $error("prescaler pulses closer than four");
    chk_t2_step: assert property (timer2_count != $past(timer2_count) |->
        timer2_count == $past(timer2_count) - 14'h1 || timer2_count inside {14'h3FFF, 14'h1FFF})
        else $error("timer 2 count jump");
    chk_pd_irq: assert property (power_down_enter |=> ##1 irq_request == 4'h0)
        else $error("request after power down");
    chk_wdog_req: assert property (!irq_request.wdog)
        else $error("watchdog request raised");
    chk_pd_presc: assert property (power_down_enter |=> ##1 !prescaler_output [*4])
        else $error("prescaler runs after power down");
    cover property (skip_nullify && skip_short);
    cover property (irq_request.t1);
    cover property (prescaler_output ##4 prescaler_output);
endmodule : tpic_ctrl_chk
bind tpic_ctrl tpic_ctrl_chk u_tpic_ctrl_chk (.*);
`default_nettype wire

// [timer_prescaler_irq_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpic_regs.svh"
module timer_prescaler_irq_control_tb;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, tl = 1'b0, pd = 1'b0;
    logic ev_ext = 1'b0, ev_t1 = 1'b0, carr = 1'b0, car_on = 1'b0, sub = 1'b0, ret = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [3:0] reg_wdata = 4'h0, reg_rdata;
    logic [1:0] op = 2'h0;
    logic s1, s2, s0, kick, nul, shrt, presc_o, t1en, t2uf, wdr, irq;
    logic [13:0] t2c, c0;
    tpic_pkg::tpic_evt_t ireq, ack = 4'h0;
    int fails = 0, checks_done = 0, n;
    always #25 clk = ~clk;
    always @(posedge clk) carr <= car_on ? ~carr : 1'b0;
    tpic_core_model u_tpic_core_model (.go(go), .op(op), .t1_skip(s1), .t2_skip(s2), .ext_skip(s0), .kick(kick));
    tpic_ctrl u_tpic_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer1_poll_skip(s1), .timer2_poll_skip(s2),
        .ext_irq_poll_skip(s0), .watchdog_kick(kick), .power_down_enter(pd), .table_lookup_instr(tl),
        .return_instr(ret), .irq_ack(ack), .external_irq_event(ev_ext), .timer1_underflow(ev_t1),
        .carrier_out(carr), .sub_osc_clock(sub), .skip_nullify(nul), .skip_short(shrt), .irq_request(ireq),
        .prescaler_output(presc_o), .timer1_count_en(t1en), .timer2_underflow(t2uf), .timer2_count(t2c),
        .watchdog_reset(wdr), .irq(irq));
    task results;
        $display("counts: fails=%0d checks=%0d", fails, checks_done);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [2:0] a, input logic [3:0] d);
        @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk); reg_wr <= 1'b0;
    endtask : wr
    task rdc(input logic [2:0] a, input logic [3:0] e);
        @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk); reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rdc
    // command strobe and the table flag share the skip cycle
    task skip(input logic [1:0] o, input logic [1:0] t);
        @(posedge clk); go <= 1'b1; op <= o; tl <= t[0]; ret <= t[1];
        @(posedge clk); go <= 1'b0; tl <= 1'b0; ret <= 1'b0;
        #1;
    endtask : skip
    task ev(input logic t1);
        @(posedge clk); if (t1) ev_t1 <= 1'b1; else ev_ext <= 1'b1;
        @(posedge clk); ev_t1 <= 1'b0; ev_ext <= 1'b0;
    endtask : ev
    task cnt(input logic sel, input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge clk); #1;
            n += sel ? t1en : presc_o;
        end
    endtask : cnt
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(`TPIC_ADDR_IE, 4'h0);
        rdc(`TPIC_ADDR_PRESC, 4'h0);
        rdc(`TPIC_ADDR_T2CFG, 4'h8);
        wr(3'h7, 4'hF);
        rdc(3'h7, 4'h0);
        wr(`TPIC_ADDR_IE, 4'h2);
        rdc(`TPIC_ADDR_IE, 4'h2);
        wr(`TPIC_ADDR_IE, 4'h0);
        ev(1'b1); skip(2'h0, 2'h1); chk({nul, shrt}, 2'h3);
        skip(2'h0, 2'h0); chk(nul, 1'b0);
        ev(1'b0); skip(2'h2, 2'h0); chk({nul, shrt}, 2'h2);
        ev(1'b0); skip(2'h2, 2'h2); chk({nul, shrt}, 2'h3);
        wr(`TPIC_ADDR_IE, 4'h5);
        ev(1'b1); ev(1'b0); skip(2'h0, 2'h0); chk(nul, 1'b0);
        skip(2'h2, 2'h0); chk({nul, ireq}, 5'h03);
        // taking the timer 1 interrupt drops only its own request
        @(posedge clk); ack <= 4'h2; @(posedge clk); ack <= 4'h0;
        #1 chk(ireq, 4'h1);
        wr(`TPIC_ADDR_PRESC, 4'h8); wr(`TPIC_ADDR_T2CFG, 4'h9);
        cnt(1'b0, 40); chk(n, 10);
        cnt(1'b1, 40); chk(n, 10);
        c0 = t2c; repeat (40) @(posedge clk); #1 chk(c0 - t2c, 14'd10);
        wr(`TPIC_ADDR_PRESC, 4'h0); wr(`TPIC_ADDR_PRESC, 4'hC);
        cnt(1'b0, 80); chk(n, 10);
        wr(`TPIC_ADDR_PRESC, 4'h0);
        cnt(1'b0, 40); chk(n, 0);
        car_on <= 1'b1;
        wr(`TPIC_ADDR_PRESC, 4'h1); cnt(1'b1, 40); chk(n, 20);
        wr(`TPIC_ADDR_PRESC, 4'h2); cnt(1'b1, 40); chk(n, 10);
        wr(`TPIC_ADDR_PRESC, 4'h3); cnt(1'b1, 40); chk(n, 0);
        wr(`TPIC_ADDR_PRESC, 4'h1); wr(`TPIC_ADDR_T2CFG, 4'h8); cnt(1'b1, 40); chk(n, 0);
        // sub clock moves only within this burst; idle it stands low
        wr(`TPIC_ADDR_T2CFG, 4'h1); c0 = t2c;
        repeat (4) begin
            repeat (10) @(posedge clk);
            sub <= ~sub;
        end
        repeat (8) @(posedge clk); #1 chk(c0 - t2c, 14'd2);
        wr(`TPIC_ADDR_T2CFG, 4'hF); wr(`TPIC_ADDR_IE, 4'hF);
        @(posedge clk); pd <= 1'b1; @(posedge clk); pd <= 1'b0;
        rdc(`TPIC_ADDR_T2CFG, 4'hE);
        rdc(`TPIC_ADDR_IE, 4'h0);
        rdc(`TPIC_ADDR_PRESC, 4'h0);
        wr(`TPIC_ADDR_MASK, 4'h1); rdc(`TPIC_ADDR_STATUS, 4'h3);
        rdc(`TPIC_ADDR_STATUS, 4'h0);
        ev(1'b0); #1 chk(irq, 1'b1); @(posedge clk); #1 chk(irq, 1'b1);
        rdc(`TPIC_ADDR_STATUS, 4'h1); @(posedge clk); #1 chk(irq, 1'b0);
        wr(`TPIC_ADDR_MASK, 4'h0); ev(1'b0); #1 chk(irq, 1'b0); @(posedge clk); #1 chk(irq, 1'b0);
        // long wait: full timer 2 run at divide by four
        wr(`TPIC_ADDR_PRESC, 4'h8); wr(`TPIC_ADDR_T2CFG, 4'hB);
        n = 0;
        while (t2uf !== 1'b1 && n < 70000) begin
            @(posedge clk); #1;
            n++;
        end
        chk({t2uf, wdr}, 2'h2);
        chk(t2c, 14'h1FFF);
        repeat (2) @(posedge clk);
        wr(`TPIC_ADDR_IE, 4'h8); skip(2'h1, 2'h0); chk({nul, ireq}, 5'h04);
        wr(`TPIC_ADDR_IE, 4'h0); skip(2'h1, 2'h0); chk({nul, ireq}, 5'h10);
        skip(2'h3, 2'h0);
        rdc(`TPIC_ADDR_WDOG, 4'h2);
        results();
    end
endmodule : timer_prescaler_irq_control_tb
`default_nettype wire
